// ==== rtl/pin_function_regs.vh ====
// Constants for the port pin function select block: offsets, reset values, decode masks.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef PIN_FUNCTION_REGS_VH
`define PIN_FUNCTION_REGS_VH

// Byte offsets of the registers
`define OFS_PORT_D 8'h00
`define OFS_PORT_E 8'h04
`define OFS_PORT_F 8'h08
`define OFS_PORT_G 8'h0C
`define OFS_PORT_H 8'h10
`define OFS_STATUS 8'h14

// Field layout: pin n uses bits 2n+1 (high) and 2n (low)
`define FIELD_W 2
`define CODE_OTHER 2'h0
`define CODE_OUTPUT 2'h1
`define CODE_IN_PULLUP 2'h2
`define CODE_IN_NOPULL 2'h3

// Status register fields
`define STAT_DEBUG_BIT 0
`define STAT_RSV_LSB 8

// Power-on reset values, normal mode (strap high) and debug mode (strap low)
`define RST_PORT_D 16'hAA8A
`define RST_PORT_E_NORMAL 16'hAAAA
`define RST_PORT_E_DEBUG 16'h2AA8
`define RST_PORT_F_NORMAL 16'hAAAA
`define RST_PORT_F_DEBUG 16'h00AA
`define RST_PORT_G_NORMAL 16'hAAAA
`define RST_PORT_G_DEBUG 16'hA200
`define RST_PORT_H_NORMAL 16'hAAAA
`define RST_PORT_H_DEBUG 16'h8AAA

// Pins on which code 00 is the other function (else reserved)
`define OTHER_MASK_D 8'hFF
`define OTHER_MASK_E 8'h34
`define OTHER_MASK_F 8'hFF
`define OTHER_MASK_G 8'hFF
`define OTHER_MASK_H 8'hFF
// Pins on which code 01 is port output (else reserved)
`define OUTPUT_MASK_D 8'hAF
`define OUTPUT_MASK_E 8'hFF
`define OUTPUT_MASK_F 8'h00
`define OUTPUT_MASK_G 8'h00
`define OUTPUT_MASK_H 8'h80

// Port G pin 0 borrows the high mode bit of pin 1
`define G_PIN0_HIGH_BIT 3
`define G_PIN0_LOW_BIT 0

`endif

// ==== rtl/pin_mode_decode.v ====
// Pin mode decoder: turns eight two-bit fields into registered pin controls.
// Assumes the field vector is already assembled by the register block.
`timescale 1ns/1ns
`include "pin_function_regs.vh"
module pin_mode_decode #(
  parameter [7:0] OTHER_MASK = 8'hFF,
  parameter [7:0] OUTPUT_MASK = 8'hFF
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Fields
  input wire [15:0] field_i,
  // Pin controls
  output reg [7:0] other_fn_o,
  output reg [7:0] drive_o,
  output reg [7:0] input_o,
  output reg [7:0] pullup_o,
  output reg [7:0] reserved_o
);

  genvar n;
  generate
    for (n = 0; n < 8; n = n + 1) begin : g_pin
      wire [1:0] code = field_i[2*n+1:2*n];
      wire rsv = ((code == `CODE_OTHER) && !OTHER_MASK[n]) ||
                 ((code == `CODE_OUTPUT) && !OUTPUT_MASK[n]);
      // Reserved codes fall back to input without pull-up so the pin never drives
      always @(posedge clk_i) begin
        if (rst_i) begin
          other_fn_o[n] <= 1'b0;
          drive_o[n] <= 1'b0;
          input_o[n] <= 1'b0;
          pullup_o[n] <= 1'b0;
          reserved_o[n] <= 1'b0;
        end else begin
          other_fn_o[n] <= (code == `CODE_OTHER) && OTHER_MASK[n];
          drive_o[n] <= (code == `CODE_OUTPUT) && OUTPUT_MASK[n];
          input_o[n] <= code[1] || rsv;
          pullup_o[n] <= (code == `CODE_IN_PULLUP);
          reserved_o[n] <= rsv;
        end
      end
    end
  endgenerate

endmodule // pin_mode_decode

// ==== rtl/port_pin_function_select.v ====
// Port pin function select: Wishbone register block for ports D to H and their pin decoders.
// Also holds a read-only status word with the latched debug mode and reserved-code flags.
// Assumes one clock, a power-on reset on rst_i and a classic Wishbone master.
// Assumes manual_rst_i is already synchronous to clk_i; it only clears the bus answer.
// Assumes the strap pin is asynchronous and steady over the last edges of power-on reset.
`timescale 1ns/1ns
`include "pin_function_regs.vh"

module port_pin_function_select (
  // Clock and power-on reset
  input wire clk_i,
  input wire rst_i,
  // Manual reset, bus side only
  input wire manual_rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Strap shared with port G pin 6
  input wire debug_mode_strap_i,
  output wire port_g_pin6_input_o,
  output wire emulation_debug_mode_o,
  // Port D pin controls
  output wire [7:0] port_d_other_fn_o,
  output wire [7:0] port_d_drive_o,
  output wire [7:0] port_d_input_o,
  output wire [7:0] port_d_pullup_o,
  // Port E pin controls
  output wire [7:0] port_e_other_fn_o,
  output wire [7:0] port_e_drive_o,
  output wire [7:0] port_e_input_o,
  output wire [7:0] port_e_pullup_o,
  // Port F pin controls
  output wire [7:0] port_f_other_fn_o,
  output wire [7:0] port_f_drive_o,
  output wire [7:0] port_f_input_o,
  output wire [7:0] port_f_pullup_o,
  // Port G pin controls
  output wire [7:0] port_g_other_fn_o,
  output wire [7:0] port_g_drive_o,
  output wire [7:0] port_g_input_o,
  output wire [7:0] port_g_pullup_o,
  // Port H pin controls
  output wire [7:0] port_h_other_fn_o,
  output wire [7:0] port_h_drive_o,
  output wire [7:0] port_h_input_o,
  output wire [7:0] port_h_pullup_o
);

  // Byte-lane merge of a 16-bit register, lanes 0 and 1 only
  function [15:0] lane_merge;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0] sel;
    begin
      lane_merge[7:0] = sel[0] ? wdata[7:0] : old_val[7:0];
      lane_merge[15:8] = sel[1] ? wdata[15:8] : old_val[15:8];
    end
  endfunction

  // Select between the two reset images by strap level
  function [15:0] reset_image;
    input strap_high;
    input [15:0] normal_val;
    input [15:0] debug_val;
    begin
      reset_image = strap_high ? normal_val : debug_val;
    end
  endfunction

  // Full compare of the byte address, so aliases of a register read as unmapped
  function reg_hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      reg_hit = (adr == ofs);
    end
  endfunction

  // Register contents
  reg [15:0] port_d_function_select_r;
  reg [15:0] port_e_function_select_r;
  reg [15:0] port_f_function_select_r;
  reg [15:0] port_g_function_select_r;
  reg [15:0] port_h_function_select_r;

  // Bus handshake
  wire bus_req;
  wire bus_wr;
  reg [31:0] rd_nxt;

  // Per-register write enables and lane-merged write data
  wire wr_d;
  wire wr_e;
  wire wr_f;
  wire wr_g;
  wire wr_h;
  wire [15:0] merged_d;
  wire [15:0] merged_e;
  wire [15:0] merged_f;
  wire [15:0] merged_g;
  wire [15:0] merged_h;

  // Reset images and status word
  wire [15:0] img_e;
  wire [15:0] img_f;
  wire [15:0] img_g;
  wire [15:0] img_h;
  reg [31:0] status_nxt;

  // Strap and decode results
  wire strap_level;
  wire [15:0] port_g_field;
  wire [7:0] rsv_d;
  wire [7:0] rsv_e;
  wire [7:0] rsv_f;
  wire [7:0] rsv_g;
  wire [7:0] rsv_h;
  wire [4:0] rsv_any;

  // Strap is sampled through a synchroniser and frozen at reset release
  strap_capture u_strap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(debug_mode_strap_i),
    .strap_level_o(strap_level),
    .debug_mode_o(emulation_debug_mode_o),
    .pin_data_o(port_g_pin6_input_o)
  );

  // A request is served once; ack drops the cycle after it is given
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;

  // One write enable per register; status and unmapped offsets have none, so writes there are lost
  assign wr_d = bus_wr && reg_hit(wb_adr_i, `OFS_PORT_D);
  assign wr_e = bus_wr && reg_hit(wb_adr_i, `OFS_PORT_E);
  assign wr_f = bus_wr && reg_hit(wb_adr_i, `OFS_PORT_F);
  assign wr_g = bus_wr && reg_hit(wb_adr_i, `OFS_PORT_G);
  assign wr_h = bus_wr && reg_hit(wb_adr_i, `OFS_PORT_H);

  // Byte lanes 0 and 1 merged into the old contents; lanes 2 and 3 are ignored
  assign merged_d = lane_merge(port_d_function_select_r, wb_dat_i, wb_sel_i);
  assign merged_e = lane_merge(port_e_function_select_r, wb_dat_i, wb_sel_i);
  assign merged_f = lane_merge(port_f_function_select_r, wb_dat_i, wb_sel_i);
  assign merged_g = lane_merge(port_g_function_select_r, wb_dat_i, wb_sel_i);
  assign merged_h = lane_merge(port_h_function_select_r, wb_dat_i, wb_sel_i);

  // Reset image per port, chosen by the strap level sampled while reset is held
  assign img_e = reset_image(strap_level, `RST_PORT_E_NORMAL, `RST_PORT_E_DEBUG);
  assign img_f = reset_image(strap_level, `RST_PORT_F_NORMAL, `RST_PORT_F_DEBUG);
  assign img_g = reset_image(strap_level, `RST_PORT_G_NORMAL, `RST_PORT_G_DEBUG);
  assign img_h = reset_image(strap_level, `RST_PORT_H_NORMAL, `RST_PORT_H_DEBUG);

  // Ack and read data; manual reset may abort a bus cycle
  always @(posedge clk_i) begin
    if (rst_i || manual_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= rd_nxt;
      end
    end
  end

  // Status word: bit 0 debug mode, live reserved-code flags from bit 8 up; writes have no effect
  always @* begin
    status_nxt = 32'h00000000;
    status_nxt[`STAT_DEBUG_BIT] = emulation_debug_mode_o;
    status_nxt[`STAT_RSV_LSB+4:`STAT_RSV_LSB] = rsv_any;
  end

  // Read mux; unmapped offsets read as zero and ignore writes
  always @* begin
    rd_nxt = 32'h00000000;
    case (wb_adr_i)
      `OFS_PORT_D: rd_nxt[15:0] = port_d_function_select_r;
      `OFS_PORT_E: rd_nxt[15:0] = port_e_function_select_r;
      `OFS_PORT_F: rd_nxt[15:0] = port_f_function_select_r;
      `OFS_PORT_G: rd_nxt[15:0] = port_g_function_select_r;
      `OFS_PORT_H: rd_nxt[15:0] = port_h_function_select_r;
      `OFS_STATUS: rd_nxt = status_nxt;
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // Port D: single reset image; only power-on reset reloads it
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_d_function_select_r <= `RST_PORT_D;
    end else if (wr_d) begin
      port_d_function_select_r <= merged_d;
    end
  end

  // Port E: reset image chosen by the latched strap
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_e_function_select_r <= img_e;
    end else if (wr_e) begin
      port_e_function_select_r <= merged_e;
    end
  end

  // Port F: reset image chosen by the latched strap
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_f_function_select_r <= img_f;
    end else if (wr_f) begin
      port_f_function_select_r <= merged_f;
    end
  end

  // Port G: reset image chosen by the latched strap
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_g_function_select_r <= img_g;
    end else if (wr_g) begin
      port_g_function_select_r <= merged_g;
    end
  end

  // Port H: reset image chosen by the latched strap
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_h_function_select_r <= img_h;
    end else if (wr_h) begin
      port_h_function_select_r <= merged_h;
    end
  end

  // Pin 0 of port G takes its high bit from bit 3; stored bit 1 is read back but unused
  assign port_g_field = {port_g_function_select_r[15:2],
                         port_g_function_select_r[`G_PIN0_HIGH_BIT],
                         port_g_function_select_r[`G_PIN0_LOW_BIT]};

  // Live flags: some pin of the port holds a reserved code
  assign rsv_any = {|rsv_h, |rsv_g, |rsv_f, |rsv_e, |rsv_d};

  // Port D decoder; pins 4 and 6 have no output code
  pin_mode_decode #(
    .OTHER_MASK(`OTHER_MASK_D),
    .OUTPUT_MASK(`OUTPUT_MASK_D)
  ) u_dec_d (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .field_i(port_d_function_select_r),
    .other_fn_o(port_d_other_fn_o),
    .drive_o(port_d_drive_o),
    .input_o(port_d_input_o),
    .pullup_o(port_d_pullup_o),
    .reserved_o(rsv_d)
  );

  // Port E decoder; 00 is reserved on pins 0, 1, 3, 6, 7
  pin_mode_decode #(
    .OTHER_MASK(`OTHER_MASK_E),
    .OUTPUT_MASK(`OUTPUT_MASK_E)
  ) u_dec_e (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .field_i(port_e_function_select_r),
    .other_fn_o(port_e_other_fn_o),
    .drive_o(port_e_drive_o),
    .input_o(port_e_input_o),
    .pullup_o(port_e_pullup_o),
    .reserved_o(rsv_e)
  );

  // Port F decoder; no pin may drive as a port output
  pin_mode_decode #(
    .OTHER_MASK(`OTHER_MASK_F),
    .OUTPUT_MASK(`OUTPUT_MASK_F)
  ) u_dec_f (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .field_i(port_f_function_select_r),
    .other_fn_o(port_f_other_fn_o),
    .drive_o(port_f_drive_o),
    .input_o(port_f_input_o),
    .pullup_o(port_f_pullup_o),
    .reserved_o(rsv_f)
  );

  // Port G decoder, fed with the pin 0 remap
  pin_mode_decode #(
    .OTHER_MASK(`OTHER_MASK_G),
    .OUTPUT_MASK(`OUTPUT_MASK_G)
  ) u_dec_g (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .field_i(port_g_field),
    .other_fn_o(port_g_other_fn_o),
    .drive_o(port_g_drive_o),
    .input_o(port_g_input_o),
    .pullup_o(port_g_pullup_o),
    .reserved_o(rsv_g)
  );

  // Port H decoder; only pin 7 has an output code
  pin_mode_decode #(
    .OTHER_MASK(`OTHER_MASK_H),
    .OUTPUT_MASK(`OUTPUT_MASK_H)
  ) u_dec_h (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .field_i(port_h_function_select_r),
    .other_fn_o(port_h_other_fn_o),
    .drive_o(port_h_drive_o),
    .input_o(port_h_input_o),
    .pullup_o(port_h_pullup_o),
    .reserved_o(rsv_h)
  );

endmodule // port_pin_function_select

// ==== rtl/strap_capture.v ====
// Strap capture: synchronises the shared strap / port G pin 6 input and holds the strap level.
// Assumes rst_i is the power-on reset, synchronous and active high, held at least four edges.
`timescale 1ns/1ns
module strap_capture (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Shared pin
  input wire pin_i,
  // Results
  output reg strap_level_o,
  output reg debug_mode_o,
  output reg pin_data_o
);

  reg sync1_r;
  reg sync2_r;

  // Two-stage synchroniser; the first stage feeds only the second
  always @(posedge clk_i) begin
    sync1_r <= pin_i;
    sync2_r <= sync1_r;
  end

  // Strap is tracked only while reset is held, then frozen
  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_level_o <= sync2_r;
      debug_mode_o <= ~sync2_r;
      pin_data_o <= 1'b0;
    end else begin
      pin_data_o <= sync2_r;
    end
  end

endmodule // strap_capture

// ==== testbench/port_pin_function_select_sva.sv ====
// Checker for the port pin function select block: bus handshake and pin decode.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
`include "pin_function_regs.vh"
module port_pin_function_select_sva (
  // Clock and resets
  input wire clk_i,
  input wire rst_i,
  input wire manual_rst_i,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  // Pin controls
  input wire emulation_debug_mode_o,
  input wire [7:0] port_d_drive_o,
  input wire [7:0] port_e_other_fn_o,
  input wire [7:0] port_f_other_fn_o,
  input wire [7:0] port_f_drive_o,
  input wire [7:0] port_f_pullup_o,
  input wire [7:0] port_g_drive_o,
  input wire [7:0] port_h_drive_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A request the slave must take; manual reset clears the answer
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !manual_rst_i;
  // Pins of a field vector that carry code c
  function automatic [7:0] pins(input [15:0] v, input [1:0] c);
    for (int n = 0; n < 8; n++) pins[n] = (v[2*n+:2] == c);
  endfunction
  a_ack_after_req: assert property (req |=> wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  a_f_write_decode: assert property (
    (req && wb_we_i && wb_adr_i == `OFS_PORT_F && wb_sel_i[1:0] == 2'h3) |=> ##1
    (port_f_pullup_o == pins($past(wb_dat_i, 2), 2'h2) && port_f_other_fn_o == pins($past(wb_dat_i, 2), 2'h0)))
    else $error("port F decode wrong");
  a_f_no_drive: assert property (port_f_drive_o == 8'h00) else $error("port F drives");
  a_g_no_drive: assert property (port_g_drive_o == 8'h00) else $error("port G drives");
  a_dh_reserved: assert property (
    port_d_drive_o[6] == 1'b0 && port_d_drive_o[4] == 1'b0 && port_h_drive_o[6:0] == 7'h00)
    else $error("reserved output code drives");
  a_e_other_pins: assert property ((port_e_other_fn_o & 8'hCB) == 8'h00) else $error("E other");
  a_mode_frozen: assert property (!$past(rst_i) |-> $stable(emulation_debug_mode_o))
    else $error("debug mode moved");
endmodule // port_pin_function_select_sva

bind port_pin_function_select port_pin_function_select_sva u_sva (.clk_i, .rst_i, .manual_rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .emulation_debug_mode_o,
  .port_d_drive_o, .port_e_other_fn_o, .port_f_other_fn_o, .port_f_drive_o, .port_f_pullup_o,
  .port_g_drive_o, .port_h_drive_o);

// ==== testbench/port_pin_function_select_test.sv ====
// Testbench for the port pin function select block: both strap modes, bus access, decode.
// Assumes the checker is bound to the block; this module drives every input.
`timescale 1ns/1ns
module port_pin_function_select_test;
  reg clk_i = 0, rst_i = 1, mrst = 0, cyc = 0, stb = 0, we = 0, strap = 1;
  reg [7:0] adr = 0;
  reg [3:0] sel = 0, s;
  reg [31:0] wdat = 0, q;
  reg [15:0] v, m [0:4];
  wire [31:0] rdat;
  wire ack, pin6, dbg;
  wire [7:0] o [0:19];
  integer n_mismatch = 0, checks = 0, cnt = 0, p, k, j;
  // Corner fields; the last two probe the borrowed high bit of port G pin 0
  localparam [79:0] CORNERS = 80'h0008_0002_FFFF_5555_0000;

  port_pin_function_select dut (.clk_i(clk_i), .rst_i(rst_i), .manual_rst_i(mrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .debug_mode_strap_i(strap), .port_g_pin6_input_o(pin6), .emulation_debug_mode_o(dbg),
    .port_d_other_fn_o(o[0]), .port_d_drive_o(o[1]), .port_d_input_o(o[2]), .port_d_pullup_o(o[3]),
    .port_e_other_fn_o(o[4]), .port_e_drive_o(o[5]), .port_e_input_o(o[6]), .port_e_pullup_o(o[7]),
    .port_f_other_fn_o(o[8]), .port_f_drive_o(o[9]), .port_f_input_o(o[10]), .port_f_pullup_o(o[11]),
    .port_g_other_fn_o(o[12]), .port_g_drive_o(o[13]), .port_g_input_o(o[14]), .port_g_pullup_o(o[15]),
    .port_h_other_fn_o(o[16]), .port_h_drive_o(o[17]), .port_h_input_o(o[18]), .port_h_pullup_o(o[19]));

  initial forever #20 clk_i = ~clk_i;

  task check(input [31:0] seen, input [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  endtask

  task results;
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Watchdog: the run needs about 850 cycles
  always @(posedge clk_i) begin
    cnt++;
    if (cnt == 5000) begin
      n_mismatch++;
      results;
    end
  end

  // One classic cycle; ack and read data are taken at the same edge, a hang ends at the watchdog
  task bus(input w, input [7:0] a, input [31:0] d, input [3:0] se);
    begin
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= se;
      do begin @(posedge clk_i); end while (ack !== 1'b1);
      q = rdat;
      cyc <= 0; stb <= 0;
    end
  endtask

  // Expected {pullup, input, drive, other} of port p for field vector f
  function [31:0] dec(input integer p, input [15:0] f);
    reg [1:0] c;
    reg [7:0] om, dm;
    begin
      om = (p == 1) ? 8'h34 : 8'hFF;
      dm = (p == 0) ? 8'hAF : (p == 1) ? 8'hFF : (p == 4) ? 8'h80 : 8'h00;
      for (int n = 0; n < 8; n++) begin
        c = (p == 3 && n == 0) ? {f[3], f[0]} : f[2*n+:2];
        dec[n] = c == 2'h0 && om[n];
        dec[8+n] = c == 2'h1 && dm[n];
        dec[16+n] = !dec[n] && !dec[8+n];
        dec[24+n] = c == 2'h2;
      end
    end
  endfunction

  // Expected status word: debug bit, then one flag per port with a pin on a reserved code
  function [31:0] stat(input d);
    reg [31:0] e;
    reg [1:0] c;
    begin
      stat = {31'h00000000, d};
      for (int x = 0; x < 5; x++) begin
        e = dec(x, m[x]);
        for (int n = 0; n < 8; n++) begin
          c = (x == 3 && n == 0) ? {m[x][3], m[x][0]} : m[x][2*n+:2];
          if (e[16+n] && !c[1]) stat[8+x] = 1'b1;
        end
      end
    end
  endfunction

  // Read back one register and compare its pin controls
  task port_chk(input integer p);
    bus(0, p * 4, 32'h0, 4'hF);
    check(q, {16'h0000, m[p]}, "readback");
    check({o[4*p+3], o[4*p+2], o[4*p+1], o[4*p]}, dec(p, m[p]), "decode");
  endtask

  initial begin
    j = $urandom(32'hE6AB);
    for (j = 1; j >= 0; j--) begin
      // Power-on reset with the strap at level j; the second pass resets mid-run
      strap <= j[0];
      rst_i <= 1;
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      m[0] = 16'hAA8A;
      m[1] = j ? 16'hAAAA : 16'h2AA8;
      m[2] = j ? 16'hAAAA : 16'h00AA;
      m[3] = j ? 16'hAAAA : 16'hA200;
      m[4] = j ? 16'hAAAA : 16'h8AAA;
      for (p = 0; p < 5; p++) port_chk(p);
      check(dbg, !j[0], "debug mode");
      bus(0, 8'h14, 32'h0, 4'hF);
      check(q, stat(!j[0]), "status after reset");
      // After reset the strap pin is plain port G pin 6
      strap <= !j[0];
      repeat (4) @(posedge clk_i);
      check(pin6, !j[0], "pin6 input");
      for (k = 0; k < 60; k++) begin
        p = k % 5;
        v = (k < 25) ? CORNERS[16*(k/5)+:16] : 16'($urandom);
        s = (k < 25) ? 4'h3 : 4'($urandom);
        bus(1, p * 4, {16'($urandom), v}, s);
        if (s[0]) m[p][7:0] = v[7:0];
        if (s[1]) m[p][15:8] = v[15:8];
        port_chk(p);
      end
      // Status is read-only and flags the reserved codes left by the random writes
      bus(1, 8'h14, 32'($urandom), 4'hF);
      bus(0, 8'h14, 32'h0, 4'hF);
      check(q, stat(!j[0]), "status");
      // Unmapped place: answered, reads zero, write lost
      bus(1, 8'h18, $urandom, 4'hF);
      bus(0, 8'h18, 32'h0, 4'hF);
      check(q, 32'h0, "unmapped");
      // Manual reset leaves the port registers alone
      mrst <= 1;
      repeat (3) @(posedge clk_i);
      mrst <= 0;
      for (p = 0; p < 5; p++) port_chk(p);
    end
    results;
  end
endmodule // port_pin_function_select_test
